// ===== emsc_defines.vh
`ifndef EMSC_DEFINES_VH
`define EMSC_DEFINES_VH

// Counter and register word offsets (byte addresses)
`define EMSC_OFS_RX_OVERSIZE 8'h00
`define EMSC_OFS_RX_LONG_ERRORED 8'h04
`define EMSC_OFS_RX_SHORT 8'h08
`define EMSC_OFS_RX_SHORT_ERRORED 8'h0c
`define EMSC_OFS_RX_ADDR_DISCARD 8'h10
`define EMSC_OFS_RX_QOS_DISCARD 8'h14
`define EMSC_OFS_RX_GOOD_BYTE 8'h18
`define EMSC_OFS_TX_GOOD 8'h1c
`define EMSC_OFS_TX_BROADCAST 8'h20
`define EMSC_OFS_TX_MULTICAST 8'h24
`define EMSC_OFS_TX_PAUSE 8'h28
`define EMSC_OFS_TX_DEFERRED 8'h2c
`define EMSC_OFS_TX_COLLISION_EVENT 8'h30
`define EMSC_OFS_TX_ONE_COLLISION 8'h34
`define EMSC_OFS_TX_SEVERAL_COLLISION 8'h38
`define EMSC_OFS_TX_ABANDONED_COLLISION 8'h3c
`define EMSC_OFS_TX_LATE_COLLISION 8'h40
`define EMSC_OFS_FRAME_64 8'h44
`define EMSC_OFS_CTRL 8'h80
`define EMSC_OFS_STATUS 8'h84

// Counter indices (offset / 4)
`define EMSC_IDX_RX_OVERSIZE 0
`define EMSC_IDX_RX_LONG_ERRORED 1
`define EMSC_IDX_RX_SHORT 2
`define EMSC_IDX_RX_SHORT_ERRORED 3
`define EMSC_IDX_RX_ADDR_DISCARD 4
`define EMSC_IDX_RX_QOS_DISCARD 5
`define EMSC_IDX_RX_GOOD_BYTE 6
`define EMSC_IDX_TX_GOOD 7
`define EMSC_IDX_TX_BROADCAST 8
`define EMSC_IDX_TX_MULTICAST 9
`define EMSC_IDX_TX_PAUSE 10
`define EMSC_IDX_TX_DEFERRED 11
`define EMSC_IDX_TX_COLLISION_EVENT 12
`define EMSC_IDX_TX_ONE_COLLISION 13
`define EMSC_IDX_TX_SEVERAL_COLLISION 14
`define EMSC_IDX_TX_ABANDONED_COLLISION 15
`define EMSC_IDX_TX_LATE_COLLISION 16
`define EMSC_IDX_FRAME_64 17
`define EMSC_NUM_COUNTERS 18

// Control register fields
`define EMSC_CTRL_GIGABIT_BIT 0
`define EMSC_CTRL_QOS_EN_BIT 1
`define EMSC_CTRL_STATS_INT_EN_BIT 2
`define EMSC_CTRL_MAXLEN_LSB 16
`define EMSC_CTRL_MAXLEN_MSB 31
`define EMSC_MAXLEN_RESET 16'h05ee

// Status register fields
`define EMSC_STAT_PEND_BIT 0
`define EMSC_STAT_CLEARING_BIT 1

// Frame size and collision figures
`define EMSC_MIN_FRAME 16'h0040
`define EMSC_LATE_COLL_BITS 16'h0200
`define EMSC_MAX_COLLISIONS 5'h10
`define EMSC_HALF_SCALE_BIT 31

// Clear delay after reset, in clock cycles
`define EMSC_CLEAR_DELAY 6'h26

`endif

// ===== emsc_counter.v
`timescale 1ns/10ps
`include "emsc_defines.vh"

module emsc_counter #(
    parameter WIDTH = 32
) (
    // Clock and control
    input wire clk,
    input wire reset,
    input wire ce,
    input wire clear,
    // Host write
    input wire wr_en,
    input wire decrement_mode,
    input wire [WIDTH-1:0] wr_data,
    // Hardware increment
    input wire [WIDTH-1:0] inc,
    // Value
    output wire [WIDTH-1:0] count
);

    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cnt_d;
    reg [WIDTH-1:0] base;

    always @* begin
        base = cnt_q;
        if (wr_en) begin
            if (decrement_mode) begin
                base = (wr_data > cnt_q) ? {WIDTH{1'b0}} : cnt_q - wr_data;
            end else begin
                base = wr_data;
            end
        end
        // Increment stacks on top of the write so no event is lost
        cnt_d = base + inc;
    end

    always @(posedge clk) begin
        if (reset) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (clear) begin
                cnt_q <= {WIDTH{1'b0}};
            end else begin
                cnt_q <= cnt_d;
            end
        end
    end

    assign count = cnt_q;

endmodule // emsc_counter

// ===== emsc_stats.v
// What this block does
// - Count accepted clean frames above maximum length
// - Count accepted errored frames above maximum length
// - Count accepted clean data frames under 64
// - Count errored short data frames, except flow jams
// - Receive overruns never affect these counts
// - Count clean data frames discarded by address
// - Count QoS drops when threshold reaches free buffers
// - Add good received frame bytes to octets
// - Count transmitted frames without abort conditions
// - Count good transmits to all-ones address
// - Count good transmits to other multicast addresses
// - Pause count only for hardware pause frames
// - Hardware pause also counts multicast and 64-byte
// - Pause frames only in full duplex
// - Count deferred frames sent without any collision
// - Count transmit collisions, late ones too, unless under carrier loss or underrun
// - Count forced collisions from half-duplex flow control
// - Count successes after exactly one collision
// - Count successes after two to fifteen collisions
// - Abandon and count on sixteenth collision
// - Collision past 512 bit-times is late, abandon
// - Late collisions excluded from single/multiple/excessive
// - Clear all counters 38 clocks after reset
// - Write decrements saturating in gigabit mode, else loads
// - Pending flag when any counter reaches half-scale
// - Counters are 32 bits and wrap
`timescale 1ns/10ps
`include "emsc_defines.vh"

module emsc_stats #(
    parameter LEN_WIDTH = 16,
    parameter BUF_WIDTH = 16
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Receive path events
    input wire rx_frame_done,
    input wire [LEN_WIDTH-1:0] rx_frame_len,
    input wire rx_is_control,
    input wire rx_addr_match,
    input wire rx_crc_err,
    input wire rx_align_err,
    input wire rx_code_err,
    input wire rx_overrun,
    input wire rx_flow_collision,
    input wire [BUF_WIDTH-1:0] rx_channel_flow_threshold,
    input wire [BUF_WIDTH-1:0] rx_channel_free_buffer_count,
    // Transmit path events
    input wire full_duplex,
    input wire flow_control_active,
    input wire rx_frame_start,
    input wire tx_collision,
    input wire [LEN_WIDTH-1:0] tx_bits_sent,
    input wire tx_frame_done,
    input wire [LEN_WIDTH-1:0] tx_frame_len,
    input wire tx_dest_broadcast,
    input wire tx_dest_multicast,
    input wire tx_hw_pause,
    input wire tx_deferred,
    input wire tx_carrier_loss,
    input wire tx_underrun,
    // Status to the MAC and system
    output reg tx_abandon,
    output reg stats_interrupt_pending
);

    localparam NC = `EMSC_NUM_COUNTERS;

    // Clear sequencer states
    localparam CLR_WAIT = 2'b00;
    localparam CLR_FIRE = 2'b01;
    localparam CLR_DONE = 2'b10;

    reg [1:0] clr_state_q;
    reg [5:0] clr_cnt_q;
    reg clear_pulse;
    wire clearing;

    // Control register
    reg gigabit_interface_enable_q;
    reg rx_qos_filter_enable_q;
    reg stats_int_enable_q;
    reg [15:0] max_rx_frame_length_q;

    // Transmit collision tracking
    reg [4:0] coll_cnt_q;

    // Increments and counter values
    reg [NC*32-1:0] inc_d;
    reg [NC*32-1:0] inc_q;
    wire [NC*32-1:0] counts;

    // APB decode
    wire access = psel & penable;
    wire wr_stb = access & pwrite & pready;
    wire [5:0] idx = paddr[7:2];
    wire in_cnt = (paddr[7] == 1'b0) && (idx < NC) && (paddr[1:0] == 2'b00);
    wire is_ctrl = (paddr == `EMSC_OFS_CTRL);
    wire is_status = (paddr == `EMSC_OFS_STATUS);

    // Receive classification
    // Control frames stay out of the short and address-discard counts, yet count when long
    wire rx_err = rx_crc_err | rx_align_err | rx_code_err;
    wire [LEN_WIDTH-1:0] max_len = max_rx_frame_length_q[LEN_WIDTH-1:0];
    wire rx_long = rx_frame_len > max_len;
    wire rx_short = rx_frame_len < `EMSC_MIN_FRAME;
    wire rx_in_range = !rx_long && !rx_short;
    wire rx_good = rx_addr_match && rx_in_range && !rx_err;

    // Transmit classification
    wire tx_clean = !tx_carrier_loss && !tx_underrun;
    // Late means past the slot time, however many retries came first
    wire tx_late = tx_collision && (tx_bits_sent > `EMSC_LATE_COLL_BITS);
    wire tx_normal_coll = tx_collision && !tx_late;
    wire tx_excess = tx_normal_coll && (coll_cnt_q == `EMSC_MAX_COLLISIONS - 5'h01);
    wire tx_ok = tx_frame_done && tx_clean;
    wire tx_pause_ok = tx_ok && tx_hw_pause && full_duplex;
    wire tx_mcast = tx_dest_multicast && !tx_dest_broadcast;
    wire forced_coll = !full_duplex && flow_control_active && rx_frame_start;
    wire rx_is_64 = rx_addr_match && (rx_frame_len == `EMSC_MIN_FRAME);
    wire tx_is_64 = (tx_frame_len == `EMSC_MIN_FRAME) || tx_pause_ok;

    // Collisions met by the frame now done; a 16th never finishes
    wire tx_no_coll = (coll_cnt_q == 5'h00);
    wire tx_one_coll = (coll_cnt_q == 5'h01);
    wire tx_several_coll = (coll_cnt_q >= 5'h02) && (coll_cnt_q < `EMSC_MAX_COLLISIONS);

    assign clearing = (clr_state_q != CLR_DONE);

    // Delayed clear after reset
    // Edge 1 is the first with reset low; the pulse leaves on edge 37,
    // so counters read zero from edge 38 and events wait until then
    always @(posedge clk) begin
        if (reset) begin
            clr_state_q <= CLR_WAIT;
            clr_cnt_q <= 6'h00;
            clear_pulse <= 1'b0;
        end else if (ce) begin
            clear_pulse <= 1'b0;
            case (clr_state_q)
                CLR_WAIT: begin
                    clr_cnt_q <= clr_cnt_q + 6'h01;
                    if (clr_cnt_q == `EMSC_CLEAR_DELAY - 6'h02) begin
                        clr_state_q <= CLR_FIRE;
                        clear_pulse <= 1'b1;
                    end
                end
                CLR_FIRE: begin
                    clr_state_q <= CLR_DONE;
                end
                CLR_DONE: begin
                    clr_state_q <= CLR_DONE;
                end
                default: begin
                    clr_state_q <= CLR_WAIT;
                end
            endcase
        end
    end

    // Per-frame collision count; reset when the frame is done or abandoned
    // A collision under carrier loss or underrun still advances the retry count
    always @(posedge clk) begin
        if (reset) begin
            coll_cnt_q <= 5'h00;
            tx_abandon <= 1'b0;
        end else if (ce) begin
            tx_abandon <= tx_late || tx_excess;
            if (tx_frame_done || tx_late || tx_excess) begin
                coll_cnt_q <= 5'h00;
            end else if (tx_normal_coll) begin
                coll_cnt_q <= coll_cnt_q + 5'h01;
            end
        end
    end

    // Increment of every counter for this cycle.
    // Overrun is deliberately left out of every term.
    always @* begin
        inc_d = {NC*32{1'b0}};
        if (rx_frame_done && !clearing) begin
            inc_d[`EMSC_IDX_RX_OVERSIZE*32 +: 32] =
                {31'h0, rx_addr_match && rx_long && !rx_err};
            inc_d[`EMSC_IDX_RX_LONG_ERRORED*32 +: 32] =
                {31'h0, rx_addr_match && rx_long && rx_err};
            inc_d[`EMSC_IDX_RX_SHORT*32 +: 32] =
                {31'h0, rx_addr_match && !rx_is_control && rx_short && !rx_err};
            inc_d[`EMSC_IDX_RX_SHORT_ERRORED*32 +: 32] =
                {31'h0, !rx_is_control && rx_short && rx_err && !rx_flow_collision};
            inc_d[`EMSC_IDX_RX_ADDR_DISCARD*32 +: 32] =
                {31'h0, !rx_is_control && !rx_err && !rx_addr_match};
            inc_d[`EMSC_IDX_RX_QOS_DISCARD*32 +: 32] =
                {31'h0, rx_qos_filter_enable_q && rx_good &&
                 (rx_channel_flow_threshold >= rx_channel_free_buffer_count)};
            if (rx_good) begin
                inc_d[`EMSC_IDX_RX_GOOD_BYTE*32 +: 32] = {{(32-LEN_WIDTH){1'b0}}, rx_frame_len};
            end
            inc_d[`EMSC_IDX_FRAME_64*32 +: 32] =
                {31'h0, rx_is_64};
        end
        if (!clearing) begin
            // Transmit and forced collisions may land together: both count
            inc_d[`EMSC_IDX_TX_COLLISION_EVENT*32 +: 32] =
                {31'h0, tx_collision && tx_clean} +
                {31'h0, forced_coll};
            inc_d[`EMSC_IDX_TX_ABANDONED_COLLISION*32 +: 32] = {31'h0, tx_excess && tx_clean};
            inc_d[`EMSC_IDX_TX_LATE_COLLISION*32 +: 32] = {31'h0, tx_late && tx_clean};
        end
        if (tx_ok && !clearing) begin
            inc_d[`EMSC_IDX_TX_GOOD*32 +: 32] = 32'h00000001;
            inc_d[`EMSC_IDX_TX_BROADCAST*32 +: 32] = {31'h0, tx_dest_broadcast};
            inc_d[`EMSC_IDX_TX_MULTICAST*32 +: 32] = {31'h0, tx_mcast || tx_pause_ok};
            inc_d[`EMSC_IDX_TX_PAUSE*32 +: 32] = {31'h0, tx_pause_ok};
            inc_d[`EMSC_IDX_TX_DEFERRED*32 +: 32] = {31'h0, tx_deferred && tx_no_coll};
            inc_d[`EMSC_IDX_TX_ONE_COLLISION*32 +: 32] = {31'h0, tx_one_coll};
            inc_d[`EMSC_IDX_TX_SEVERAL_COLLISION*32 +: 32] =
                {31'h0, tx_several_coll};
            inc_d[`EMSC_IDX_FRAME_64*32 +: 32] = inc_d[`EMSC_IDX_FRAME_64*32 +: 32] +
                {31'h0, tx_is_64};
        end
    end

    // One register stage so all counters of a frame step on the same edge
    // Costs a cycle before a read sees an event, but keeps classifiers off the adders
    always @(posedge clk) begin
        if (reset) begin
            inc_q <= {NC*32{1'b0}};
        end else if (ce) begin
            inc_q <= inc_d;
        end
    end

    // One counter per statistic, each with its own write strobe
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi = gi + 1) begin : g_cnt
            emsc_counter #(
                .WIDTH(32)
            ) u_counter (
                .clk(clk),
                .reset(reset),
                .ce(ce),
                .clear(clear_pulse),
                .wr_en(wr_stb && in_cnt && (idx == gi)),
                .decrement_mode(gigabit_interface_enable_q),
                .wr_data(pwdata),
                .inc(inc_q[gi*32 +: 32]),
                .count(counts[gi*32 +: 32])
            );
        end
    endgenerate

    // Half-scale detection over all counters
    // Bit 31 alone decides: it is set exactly when a value reaches half-scale
    reg any_half;
    integer hi;
    always @* begin
        any_half = 1'b0;
        for (hi = 0; hi < NC; hi = hi + 1) begin
            any_half = any_half | counts[hi*32 + `EMSC_HALF_SCALE_BIT];
        end
    end

    // Control register writes
    // The length limit is inclusive: a frame of exactly that size is in range
    always @(posedge clk) begin
        if (reset) begin
            gigabit_interface_enable_q <= 1'b0;
            rx_qos_filter_enable_q <= 1'b0;
            stats_int_enable_q <= 1'b0;
            max_rx_frame_length_q <= `EMSC_MAXLEN_RESET;
        end else if (ce) begin
            if (wr_stb && is_ctrl) begin
                gigabit_interface_enable_q <= pwdata[`EMSC_CTRL_GIGABIT_BIT];
                rx_qos_filter_enable_q <= pwdata[`EMSC_CTRL_QOS_EN_BIT];
                stats_int_enable_q <= pwdata[`EMSC_CTRL_STATS_INT_EN_BIT];
                max_rx_frame_length_q <= pwdata[`EMSC_CTRL_MAXLEN_MSB:`EMSC_CTRL_MAXLEN_LSB];
            end
        end
    end

    // Pending flag follows the counters; it drops once software decrements them
    // With the enable low the flag stays clear whatever the counters hold
    always @(posedge clk) begin
        if (reset) begin
            stats_interrupt_pending <= 1'b0;
        end else if (ce) begin
            stats_interrupt_pending <= stats_int_enable_q && any_half;
        end
    end

    // APB: one wait state; read data sampled in the first access cycle
    // Every transfer is answered; unmapped words raise pslverr instead of stalling
    // Status is read-only: a write there completes and changes nothing
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h00000000;
        if (in_cnt) begin
            rd_d = counts[idx*32 +: 32];
        end else if (is_ctrl) begin
            rd_d[`EMSC_CTRL_GIGABIT_BIT] = gigabit_interface_enable_q;
            rd_d[`EMSC_CTRL_QOS_EN_BIT] = rx_qos_filter_enable_q;
            rd_d[`EMSC_CTRL_STATS_INT_EN_BIT] = stats_int_enable_q;
            rd_d[`EMSC_CTRL_MAXLEN_MSB:`EMSC_CTRL_MAXLEN_LSB] = max_rx_frame_length_q;
        end else if (is_status) begin
            rd_d[`EMSC_STAT_PEND_BIT] = stats_interrupt_pending;
            rd_d[`EMSC_STAT_CLEARING_BIT] = clearing;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            if (access && !pready) begin
                pready <= 1'b1;
                pslverr <= !(in_cnt || is_ctrl || is_status);
                prdata <= pwrite ? 32'h00000000 : rd_d;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

endmodule // emsc_stats

// ===== emsc_stats_monitor.sv
`timescale 1ns/10ps
module emsc_stats_monitor #(
    parameter LEN_WIDTH = 16
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    input wire ce,
    // APB
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Transmit side
    input wire tx_collision,
    input wire [LEN_WIDTH-1:0] tx_bits_sent,
    input wire tx_carrier_loss,
    input wire tx_underrun,
    input wire tx_abandon,
    input wire stats_interrupt_pending
);
    // Counter events are dropped while the post-reset clear runs; tx_abandon is not gated, yet the late-abandon check waits it out
    reg [5:0] up_q;
    wire [5:0] up_d = (up_q == 6'h3f) ? up_q : up_q + 6'h01;
    always @(posedge clk) begin
        up_q <= reset ? 6'h00 : up_d;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_access;
        ce && psel && penable && !pready;
    endsequence
    sequence s_late_hit;
        up_q >= 6'h28 && ce && tx_collision && tx_bits_sent > 16'h0200 && !tx_carrier_loss && !tx_underrun;
    endsequence
    chk_ready_wait: assert property (s_access |=> pready)
        else $error("no pready one cycle after access");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    chk_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without a held access");
    chk_err_unmapped: assert property (pready && paddr > 8'h84 |-> pslverr)
        else $error("unmapped address answered without error");
    chk_err_mapped: assert property (pready && paddr <= 8'h44 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("counter access answered with error");
    chk_abandon_late: assert property (s_late_hit |=> tx_abandon)
        else $error("late collision did not abandon");
    chk_abandon_cause: assert property (tx_abandon |-> $past(tx_collision))
        else $error("abandon without a collision");
    chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !pready && !pslverr && !tx_abandon
        && !stats_interrupt_pending && prdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule // emsc_stats_monitor

bind emsc_stats emsc_stats_monitor #(.LEN_WIDTH(LEN_WIDTH)) i_mon (
    .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_collision(tx_collision), .tx_bits_sent(tx_bits_sent),
    .tx_carrier_loss(tx_carrier_loss), .tx_underrun(tx_underrun), .tx_abandon(tx_abandon),
    .stats_interrupt_pending(stats_interrupt_pending)
);

// ===== emsc_mac_model.sv
`timescale 1ns/10ps
module emsc_mac_model (
    // Clock
    input wire clk,
    // Event pulses
    output logic rx_done,
    output logic rx_start,
    output logic tx_coll,
    output logic tx_done,
    // Qualifiers, garbage outside their pulse
    output logic [15:0] len,
    output logic [15:0] bits,
    output logic [15:0] fl
);
    initial begin
        {rx_done, rx_start, tx_coll, tx_done} = 4'h0;
        {len, bits, fl} = 48'h0;
    end
    // Kind 0 receive, 1 transmit, 2 forced collision; fl[13] ends the frame in a late collision
    task play(input logic [1:0] k, input logic [15:0] n, input logic [15:0] f, input logic [4:0] c);
        integer i;
        begin
            @(posedge clk);
            len <= n;
            fl <= f;
            if (k == 2'd0) rx_done <= 1'b1;
            else if (k == 2'd2) rx_start <= 1'b1;
            else begin
                for (i = 0; i < c + f[13]; i++) begin
                    tx_coll <= 1'b1;
                    bits <= (i == c) ? 16'h0258 : 16'h0064;
                    @(posedge clk);
                    tx_coll <= 1'b0;
                    bits <= ~bits;
                    @(posedge clk);
                end
                if (c < 5'd16 && !f[13]) tx_done <= 1'b1;
            end
            @(posedge clk);
            {rx_done, rx_start, tx_done} <= 3'b000;
            len <= ~n;
            // Duplex and flow-control levels are held, the rest is inverted
            fl <= f ^ 16'h3fff;
        end
    endtask
endmodule // emsc_mac_model

// ===== tb_top.sv
`timescale 1ns/10ps
`include "emsc_defines.vh"
module tb_top;
    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] len;
        logic [15:0] fl;
        logic [4:0] nc;
        logic [3:0] free;
        logic [17:0] exp;
    } emsc_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1, ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    logic [15:0] free = 16'h0009;
    logic e;
    wire [31:0] prdata;
    wire pready, pslverr, tx_abandon, stats_interrupt_pending, rx_done, rx_start, tx_coll, tx_done;
    wire [15:0] ev_len, ev_bits, ev_fl;
    integer error_cnt = 0, comparisons = 0, r, i;
    logic [31:0] exp_q [0:17];
    emsc_row_t row;
    emsc_row_t rows [0:27] = '{
        '{2'd0, 16'd1519, 16'h0022, 5'd0, 4'd9, 18'h00001},
        '{2'd0, 16'd1519, 16'h0006, 5'd0, 4'd9, 18'h00002},
        '{2'd0, 16'd63, 16'h0002, 5'd0, 4'd9, 18'h00004},
        '{2'd0, 16'd63, 16'h0003, 5'd0, 4'd9, 18'h00000},
        '{2'd0, 16'd63, 16'h0008, 5'd0, 4'd9, 18'h00008},
        '{2'd0, 16'd63, 16'h0050, 5'd0, 4'd9, 18'h00000},
        '{2'd0, 16'd100, 16'h0000, 5'd0, 4'd9, 18'h00010},
        '{2'd0, 16'd64, 16'h0002, 5'd0, 4'd9, 18'h20040},
        '{2'd0, 16'd1518, 16'h0022, 5'd0, 4'd9, 18'h00040},
        '{2'd0, 16'd64, 16'h0002, 5'd0, 4'd4, 18'h20060},
        '{2'd0, 16'd1519, 16'h0002, 5'd0, 4'd4, 18'h00001},
        '{2'd0, 16'd100, 16'h0022, 5'd0, 4'd5, 18'h00060},
        '{2'd1, 16'd100, 16'h4000, 5'd0, 4'd9, 18'h00080},
        '{2'd1, 16'd64, 16'h4080, 5'd0, 4'd9, 18'h20180},
        '{2'd1, 16'd64, 16'h4100, 5'd0, 4'd9, 18'h20280},
        '{2'd1, 16'd64, 16'h4300, 5'd0, 4'd9, 18'h20680},
        '{2'd1, 16'd64, 16'h0300, 5'd0, 4'd9, 18'h20280},
        '{2'd1, 16'd100, 16'h4400, 5'd0, 4'd9, 18'h00880},
        '{2'd1, 16'd100, 16'h0400, 5'd1, 4'd9, 18'h03080},
        '{2'd1, 16'd100, 16'h0000, 5'd2, 4'd9, 18'h05080},
        '{2'd1, 16'd100, 16'h0000, 5'd15, 4'd9, 18'h05080},
        '{2'd1, 16'd100, 16'h0000, 5'd16, 4'd9, 18'h09000},
        '{2'd1, 16'd100, 16'h2000, 5'd3, 4'd9, 18'h11000},
        '{2'd1, 16'd100, 16'h2000, 5'd15, 4'd9, 18'h11000},
        '{2'd1, 16'd100, 16'h0800, 5'd1, 4'd9, 18'h00000},
        '{2'd1, 16'd64, 16'h1000, 5'd0, 4'd9, 18'h00000},
        '{2'd2, 16'd100, 16'h8000, 5'd0, 4'd9, 18'h01000},
        '{2'd2, 16'd100, 16'hc000, 5'd0, 4'd9, 18'h00000}
    };
    emsc_mac_model i_mac (.clk(clk), .rx_done(rx_done), .rx_start(rx_start), .tx_coll(tx_coll),
        .tx_done(tx_done), .len(ev_len), .bits(ev_bits), .fl(ev_fl));
    emsc_stats i_dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_frame_done(rx_done), .rx_frame_len(ev_len), .rx_is_control(ev_fl[0]), .rx_addr_match(ev_fl[1]),
        .rx_crc_err(ev_fl[2]), .rx_align_err(ev_fl[3]), .rx_code_err(ev_fl[4]), .rx_overrun(ev_fl[5]),
        .rx_flow_collision(ev_fl[6]), .rx_channel_flow_threshold(16'h0005), .rx_channel_free_buffer_count(free),
        .full_duplex(ev_fl[14]), .flow_control_active(ev_fl[15]), .rx_frame_start(rx_start),
        .tx_collision(tx_coll), .tx_bits_sent(ev_bits), .tx_frame_done(tx_done), .tx_frame_len(ev_len),
        .tx_dest_broadcast(ev_fl[7]), .tx_dest_multicast(ev_fl[8]), .tx_hw_pause(ev_fl[9]),
        .tx_deferred(ev_fl[10]), .tx_carrier_loss(ev_fl[11]), .tx_underrun(ev_fl[12]),
        .tx_abandon(tx_abandon), .stats_interrupt_pending(stats_interrupt_pending));
    initial forever #50 clk = ~clk;
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n == 20) error_cnt++;
            if (n == 20) $display("ERROR %0t: no pready", $time);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task check(input logic [31:0] seen, input logic [31:0] want);
        begin
            comparisons++;
            if (seen !== want) begin
                error_cnt++;
                $display("ERROR %0t: saw %h expected %h", $time, seen, want);
            end
        end
    endtask
    task chk_all;
        integer k;
        begin
            for (k = 0; k < 18; k++) begin
                apb(1'b0, {k[5:0], 2'b00}, 32'h0, q, e);
                check(q, exp_q[k]);
            end
        end
    endtask
    // A write and an event during the clear must both be wiped
    task do_reset;
        integer k;
        begin
            reset <= 1'b1;
            repeat (10) @(posedge clk);
            reset <= 1'b0;
            apb(1'b1, `EMSC_OFS_TX_GOOD, 32'h5, q, e);
            i_mac.play(2'd1, 16'd100, 16'h4000, 5'd0);
            apb(1'b0, `EMSC_OFS_STATUS, 32'h0, q, e);
            check(q, 32'h2);
            repeat (40) @(posedge clk);
            for (k = 0; k < 18; k++) exp_q[k] = 32'h0;
            chk_all;
        end
    endtask
    task close_out;
        begin
            if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        do_reset;
        apb(1'b1, `EMSC_OFS_CTRL, 32'h05ee0002, q, e);
        for (r = 0; r < 28; r++) begin
            row = rows[r];
            free <= {12'h000, row.free};
            i_mac.play(row.kind, row.len, row.fl, row.nc);
            for (i = 0; i < 18; i++) if (row.exp[i]) exp_q[i] = exp_q[i] + ((i == 12) ? ((row.kind == 2'd2) ?
                32'h1 : {27'h0, row.nc} + {31'h0, row.fl[13]}) : (i == 6) ? {16'h0, row.len} : 32'h1);
            chk_all;
        end
        apb(1'b1, `EMSC_OFS_TX_GOOD, 32'h12345678, q, e);
        apb(1'b0, `EMSC_OFS_TX_GOOD, 32'h0, q, e);
        check(q, 32'h12345678);
        apb(1'b1, `EMSC_OFS_CTRL, 32'h05ee0003, q, e);
        apb(1'b1, `EMSC_OFS_TX_GOOD, 32'h8, q, e);
        apb(1'b0, `EMSC_OFS_TX_GOOD, 32'h0, q, e);
        check(q, 32'h12345670);
        apb(1'b1, `EMSC_OFS_TX_GOOD, 32'h20000000, q, e);
        apb(1'b0, `EMSC_OFS_TX_GOOD, 32'h0, q, e);
        check(q, 32'h0);
        apb(1'b1, `EMSC_OFS_CTRL, 32'h05ee0004, q, e);
        apb(1'b1, `EMSC_OFS_TX_GOOD, 32'hffffffff, q, e);
        repeat (2) @(posedge clk);
        check({31'h0, stats_interrupt_pending}, 32'h1);
        i_mac.play(2'd1, 16'd100, 16'h4000, 5'd0);
        apb(1'b0, `EMSC_OFS_TX_GOOD, 32'h0, q, e);
        check(q, 32'h0);
        ce <= 1'b0;
        i_mac.play(2'd1, 16'd100, 16'h4000, 5'd0);
        ce <= 1'b1;
        apb(1'b0, `EMSC_OFS_TX_GOOD, 32'h0, q, e);
        check(q, 32'h0);
        apb(1'b0, `EMSC_OFS_STATUS, 32'h0, q, e);
        check(q, 32'h0);
        apb(1'b0, 8'h90, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        do_reset;
        close_out;
    end
    initial begin
        #(100 * 10000);
        error_cnt++;
        close_out;
    end
endmodule // tb_top
